// ===== sim/fnd_loop_model.sv
// Loop partner: VCO and crystal ticks, phase detector.
`timescale 1ns/1ps
module fnd_loop_model
(
    input  wire logic clk_in,        // Core clock.
    input  wire logic rstn_in,       // Reset, active low.
    input  wire logic bias_en_in,    // Charge phase running.
    input  wire logic sample_in,     // Sequence finished.
    input  wire logic slow_in,       // Answer the hold phase late.
    output logic      vco_tick_out,  // VCO cycle tick.
    output logic      xtal_tick_out, // Crystal cycle tick.
    output logic      pd_resp_out,   // Detector has responded.
    output logic      pd_active_out  // Detector current flows.
);
    logic       bias_q; // Last bias level.
    logic       busy_q; // Between charge end and sample.
    logic [5:0] cnt_q;  // Cycles since the charge ended.
    wire  [5:0] hold_w = slow_in ? 6'h14 : 6'h01; // Response delay.
    // Driven on the falling edge so the design always samples settled levels.
    always @(negedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            {bias_q, busy_q, cnt_q, vco_tick_out, xtal_tick_out, pd_resp_out, pd_active_out} <= '0;
        end
        else
        begin
            bias_q        <= bias_en_in;
            vco_tick_out  <= 1'b1;
            xtal_tick_out <= 1'b1;
            busy_q        <= (bias_q && !bias_en_in) || (busy_q && !sample_in);
            cnt_q         <= busy_q ? cnt_q + 6'h01 : 6'h00;
            // Current flows for six cycles once the detector answers.
            pd_resp_out   <= busy_q && !sample_in && cnt_q >= hold_w;
            pd_active_out <= busy_q && !sample_in && cnt_q >= hold_w && cnt_q < hold_w + 6'h06;
        end
    end
endmodule : fnd_loop_model

// ===== sim/fnd_top_properties.sv
// Checks on the top-level ports of the divider control.
`timescale 1ns/1ps
module fnd_top_properties
(
    input wire logic        core_clk_in,     // Clock.
    input wire logic        rstn_in,         // Reset, active low.
    input wire logic        xtal_tick_in,    // Crystal tick.
    input wire logic        ext_en_in,       // Lock enable.
    input wire logic        load_in,         // Divisor load.
    input wire logic [11:0] int_bcd_in,      // Integer part.
    input wire logic        pd_resp_in,      // Detector answered.
    input wire logic        ref_out,         // Reference pulse.
    input wire logic        swallow_out,     // Swallow pulse.
    input wire logic        bias_en_out,     // Bias enable.
    input wire logic        comp_en_out,     // Compensation enable.
    input wire logic [4:0]  comp_level_out,  // Compensation level.
    input wire logic        disch_en_out,    // Discharge enable.
    input wire logic        sample_out,      // Sample pulse.
    input wire logic        divisor_err_out, // Load rejected.
    input wire logic        unlock_out       // Unlock flag.
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    logic [9:0] xt_q;   // Crystal ticks since the last reference pulse.
    logic       seen_q; // A first reference pulse has passed; earlier gaps are partial.
    logic [5:0] run_q;  // Length of the current compensation interval.
    // Helper counters for exact-figure checks.
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            {xt_q, seen_q, run_q} <= '0;
        end
        else
        begin
            xt_q   <= ref_out ? 10'(xtal_tick_in) : xt_q + 10'(xtal_tick_in);
            seen_q <= seen_q | ref_out;
            run_q  <= comp_en_out ? run_q + 6'h01 : 6'h00;
        end
    end
    AST_ERR_RANGE: assert property (load_in && (int_bcd_in < 12'h400 || int_bcd_in > 12'h530) |-> ##2 divisor_err_out)
        else $error("bad range kept");
    AST_ERR_STANDS: assert property (!$past(load_in) && !$past(load_in, 2) |-> $stable(divisor_err_out))
        else $error("err moved");
    AST_CHARGE: assert property ($rose(bias_en_out) |-> (bias_en_out && !comp_en_out) [*8])
        else $error("short charge");
    AST_COMP_BIAS: assert property (comp_en_out |-> bias_en_out)
        else $error("comp no bias");
    AST_COMP_LEN: assert property ($fell(comp_en_out) |-> run_q == {1'b0, $past(comp_level_out)})
        else $error("comp length");
    AST_DISCH_AFTER: assert property ($rose(disch_en_out) |-> $past(pd_resp_in) || $past(pd_resp_in, 2))
        else $error("early discharge");
    AST_SAMPLE: assert property ($fell(disch_en_out) |-> ##[0:1] sample_out ##1 !sample_out)
        else $error("no sample");
    AST_REF: assert property (ref_out && seen_q |-> xt_q == 10'd400)
        else $error("ref period");
    AST_SWALLOW: assert property (swallow_out |=> !swallow_out)
        else $error("long swallow");
    AST_UNLOCK_OFF: assert property (!$past(ext_en_in) && !$past(ext_en_in, 2) |-> !unlock_out)
        else $error("unlock while off");
endmodule : fnd_top_properties
bind fnd_top fnd_top_properties u_props (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .xtal_tick_in(xtal_tick_in), .ext_en_in(ext_en_in), .load_in(load_in), .int_bcd_in(int_bcd_in),
    .pd_resp_in(pd_resp_in), .ref_out(ref_out), .swallow_out(swallow_out), .bias_en_out(bias_en_out),
    .comp_en_out(comp_en_out), .comp_level_out(comp_level_out), .disch_en_out(disch_en_out),
    .sample_out(sample_out), .divisor_err_out(divisor_err_out), .unlock_out(unlock_out));

// ===== sim/test_fnd_top.sv
// Self-checking bench for the fractional-N divider control.
`timescale 1ns/1ps
module test_fnd_top;
    import fnd_pkg::*;
    logic core_clk_in = 1'b0, rstn_in = 1'b0, load_in = 1'b0, ext_en_in = 1'b0, ext_sel_10m_in = 1'b0;
    logic ext_tick_in = 1'b0, slow = 1'b0;
    logic [11:0] int_bcd_in = 12'h400;
    fnd_frac_t frac_bcd_in = 20'h00000;
    logic vco_tick, xtal_tick, pd_resp, pd_active, div_out, ref_out, swallow, bias_en, comp_en, disch_en;
    logic sample, overrun, err, unlock;
    logic [4:0] level;
    int fail_count = 0, comparisons = 0, cyc = 0, divs = 0, swals = 0, refs = 0, samps = 0;
    int ext_mod = 0, span, sw, r0, s0, c, ovrs = 0;
    fnd_top #(.LOCK_WIN(20)) dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .vco_tick_in(vco_tick),
        .xtal_tick_in(xtal_tick), .ext_tick_in(ext_tick_in), .ext_sel_10m_in(ext_sel_10m_in), .ext_en_in(ext_en_in),
        .load_in(load_in), .int_bcd_in(int_bcd_in), .frac_bcd_in(frac_bcd_in), .pd_resp_in(pd_resp),
        .pd_active_in(pd_active), .div_out(div_out), .ref_out(ref_out), .swallow_out(swallow), .bias_en_out(bias_en),
        .comp_en_out(comp_en), .comp_level_out(level), .disch_en_out(disch_en), .sample_out(sample),
        .overrun_out(overrun), .divisor_err_out(err), .unlock_out(unlock));
    fnd_loop_model u_loop (.clk_in(core_clk_in), .rstn_in(rstn_in), .bias_en_in(bias_en), .sample_in(sample),
        .slow_in(slow), .vco_tick_out(vco_tick), .xtal_tick_out(xtal_tick), .pd_resp_out(pd_resp),
        .pd_active_out(pd_active));
    always #50 core_clk_in = ~core_clk_in;
    // Event counters and hang limit; the run needs about 21000 cycles.
    always @(posedge core_clk_in)
    begin
        cyc++;
        divs += div_out;
        swals += swallow;
        refs += ref_out;
        samps += sample;
        ovrs += overrun;
        if (cyc >= 60000)
        begin
            fail_count++;
            finish_test();
        end
    end
    // External tick every ext_mod cycles; none when zero.
    always @(negedge core_clk_in) ext_tick_in <= (ext_mod != 0) && (cyc % ext_mod == 0);
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end
    endtask : check
    // Load pulse; the status settles two edges later.
    task load(input logic [11:0] n, input fnd_frac_t f);
        @(negedge core_clk_in);
        load_in = 1'b1; int_bcd_in = n; frac_bcd_in = f;
        @(negedge core_clk_in);
        load_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
    endtask : load
    // Cycles and swallows over n divider periods.
    task measure(input int n);
        int c0, s0, d0;
        d0 = divs;
        while (divs == d0) @(negedge core_clk_in);
        c0 = cyc; s0 = swals; d0 = divs;
        while (divs < d0 + n) @(negedge core_clk_in);
        span = cyc - c0; sw = swals - s0;
    endtask : measure
    // Sets up the reference, waits, checks the flag.
    task lock(input logic en, input logic sel, input int m, input logic exp);
        ext_en_in = en; ext_sel_10m_in = sel; ext_mod = m;
        repeat (300) @(negedge core_clk_in);
        check(32'(unlock), 32'(exp));
    endtask : lock
    task finish_test;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (20) @(negedge core_clk_in);
        rstn_in = 1'b1;
        load(12'h400, 20'h00000); check(32'(err), 0);
        measure(2); check(span, 1600);
        check(sw, 0);
        load(12'h400, 20'h50000); measure(10); check(span, 8005);
        check(sw, 5);
        load(12'h530, 20'h00000); measure(2); check(span, 2120);
        load(12'h3ff, 20'h00000); check(32'(err), 1);
        load(12'h531, 20'h00000); check(32'(err), 1);
        load(12'h40a, 20'h00000); check(32'(err), 1);
        load(12'h400, 20'h0000a); check(32'(err), 1);
        measure(1); check(span, 1060);
        // Charge length, one sequence per reference, slow detector.
        load(12'h530, 20'h90000);
        slow = 1'b1;
        while (!bias_en) @(negedge core_clk_in);
        c = 0;
        while (bias_en && !comp_en) begin c++; @(negedge core_clk_in); end
        check(c, 10);
        r0 = refs;
        while (refs == r0) @(negedge core_clk_in);
        r0 = refs; s0 = samps;
        while (refs < r0 + 5) @(negedge core_clk_in);
        check(samps - s0, 5);
        check(ovrs, 0);
        // Lock detection on both reference rates.
        lock(1'b1, 1'b1, 4, 1'b0);
        lock(1'b1, 1'b1, 1, 1'b1);
        lock(1'b1, 1'b0, 40, 1'b0);
        lock(1'b0, 1'b0, 1, 1'b0);
        finish_test();
    end
endmodule : test_fnd_top

// ===== src/fnd_bcd_acc.sv
// Decimal phase accumulator whose carry becomes the pulse-swallow command.
`timescale 1ns/1ps
`include "fnd_regs.svh"
module fnd_bcd_acc
    import fnd_pkg::*;
(
    input  wire logic core_clk_in, // Core clock.
    input  wire logic rstn_in,     // Asynchronous reset, active low.
    fnd_link_if.acc   link         // Divider side link.
);
    fnd_frac_t  sum_q;     // Phase register.
    fnd_frac_t  sum_w;     // Decimal sum, carry removed.
    logic [5:0] carry_w;   // Digit carry chain.
    logic       swallow_q; // Registered carry.

    assign carry_w[0] = 1'b0;
    // Decimal digit adders; the top carry means the sum reached one.
    for (genvar i = 0; i < 5; i++)
    begin : g_digit
        wire logic [4:0] raw_w = 5'(link.frac[4*i +: 4]) + 5'(sum_q[4*i +: 4]) + 5'(carry_w[i]);
        assign carry_w[i+1]   = (raw_w > 5'h09);
        assign sum_w[4*i +: 4] = carry_w[i+1] ? 4'(raw_w - 5'h0a) : raw_w[3:0];
    end

    // Adds once per divider output; the reload clears the sum to zero.
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sum_q     <= `FND_ACC_RST;
            swallow_q <= 1'b0;
        end
        else if (link.load)
        begin
            sum_q     <= `FND_ACC_RST;
            swallow_q <= 1'b0;
        end
        else
        begin
            swallow_q <= link.div_tick & carry_w[5];
            if (link.div_tick)
                sum_q <= sum_w;
        end
    end

    assign link.swallow   = swallow_q;
    // Top five phase bits steer the compensation current.
    assign link.comp_bits = sum_q[19:15];
endmodule : fnd_bcd_acc

// ===== src/fnd_comp_seq.sv
// Per-reference-cycle charge, compensate, hold, discharge and sample sequencer.
`timescale 1ns/1ps
`include "fnd_regs.svh"
module fnd_comp_seq
    import fnd_pkg::*;
(
    input  wire logic       core_clk_in,  // Core clock.
    input  wire logic       rstn_in,      // Asynchronous reset, active low.
    fnd_link_if.seq         link,         // Reference tick and control bits.
    input  wire logic       pd_resp_in,   // Phase detector has produced its output.
    input  wire logic       pd_active_in, // Phase detector current flows.
    output logic            bias_en_out,  // Bias charging enabled.
    output logic            comp_en_out,  // Compensation current enabled.
    output logic [4:0]      level_out,    // Compensation current magnitude.
    output logic            disch_en_out, // Discharge by detector current.
    output logic            sample_out,   // Sample-hold retain command.
    output logic            overrun_out   // Reference tick seen while busy.
);
    fnd_seq_e   st_q;     // Sequencer state.
    logic [7:0] cnt_q;    // Interval counter.
    logic [4:0] level_q;  // Bits latched at cycle start.
    wire  logic cnt_done_w = (cnt_q <= 8'h01);

    // A tick while busy is ignored so a running sequence keeps its sample.
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_q    <= SEQ_IDLE;
            cnt_q   <= 8'h00;
            level_q <= 5'h00;
        end
        else
        begin
            case (st_q)
                SEQ_IDLE:
                    if (link.ref_tick)
                    begin
                        st_q    <= SEQ_CHARGE;
                        cnt_q   <= `FND_T_CHARGE_CYC;
                        level_q <= link.comp_bits;
                    end
                SEQ_CHARGE:
                    if (cnt_done_w)
                    begin
                        st_q  <= (level_q == 5'h00) ? SEQ_HOLD : SEQ_COMP;
                        cnt_q <= 8'(level_q) * `FND_COMP_STEP_CYC;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                SEQ_COMP:
                    if (cnt_done_w)
                        st_q <= SEQ_HOLD;
                    else
                        cnt_q <= cnt_q - 8'h01;
                SEQ_HOLD:
                    if (pd_resp_in)
                        st_q <= SEQ_DISCH;
                SEQ_DISCH:
                    if (!pd_active_in)
                        st_q <= SEQ_SAMPLE;
                SEQ_SAMPLE:
                    st_q <= SEQ_IDLE;
                default:
                    st_q <= SEQ_IDLE;
            endcase
        end
    end

    assign bias_en_out  = (st_q == SEQ_CHARGE) | (st_q == SEQ_COMP);
    assign comp_en_out  = (st_q == SEQ_COMP);
    assign level_out    = level_q;
    assign disch_en_out = (st_q == SEQ_DISCH);
    assign sample_out   = (st_q == SEQ_SAMPLE);
    assign overrun_out  = link.ref_tick & (st_q != SEQ_IDLE);
endmodule : fnd_comp_seq

// ===== src/fnd_link_if.sv
// Link between the divider, accumulator and sequencer.
`timescale 1ns/1ps
interface fnd_link_if;
    import fnd_pkg::*;
    logic      div_tick;  // One pulse per divided-counter output cycle.
    logic      ref_tick;  // One pulse per loop reference cycle.
    logic      load;      // Divisor reload pulse.
    fnd_frac_t frac;      // Fractional part of the divisor.
    logic      swallow;   // Carry out of the accumulator.
    logic [4:0] comp_bits; // Control bits for the compensation current.
    modport acc (input div_tick, load, frac, output swallow, comp_bits);
    modport seq (input ref_tick, comp_bits);
    modport top (output div_tick, ref_tick, load, frac, input swallow, comp_bits);
endinterface : fnd_link_if

// ===== src/fnd_pkg.sv
// Types shared by the fractional-N divider control modules.
package fnd_pkg;
    // Compensation sequencer states, one-hot.
    typedef enum logic [5:0] {
        SEQ_IDLE   = 6'h01,
        SEQ_CHARGE = 6'h02,
        SEQ_COMP   = 6'h04,
        SEQ_HOLD   = 6'h08,
        SEQ_DISCH  = 6'h10,
        SEQ_SAMPLE = 6'h20
    } fnd_seq_e;
    typedef logic [19:0] fnd_frac_t; // Five BCD fractional digits.
endpackage : fnd_pkg

// ===== src/fnd_regs.svh
// Constants of the fractional-N divider control.
`ifndef FND_REGS_SVH
`define FND_REGS_SVH
`define FND_CLK_NS        100
`define FND_XTAL_HZ       40000000
`define FND_LOOP_REF_HZ   100000
`define FND_REF_DIV       16'(`FND_XTAL_HZ / `FND_LOOP_REF_HZ)
`define FND_REF_DIV_W     16
`define FND_TEN_M_DIV     3'd4
`define FND_T_CHARGE_NS   1000
`define FND_T_CHARGE_CYC  8'((`FND_T_CHARGE_NS + `FND_CLK_NS - 1) / `FND_CLK_NS)
`define FND_COMP_STEP_NS  100
`define FND_COMP_STEP_CYC 8'((`FND_COMP_STEP_NS + `FND_CLK_NS - 1) / `FND_CLK_NS)
`define FND_INT_MIN       12'h400
`define FND_INT_MAX       12'h530
`define FND_PROG_TERM     12'h998
`define FND_PROG_RST      12'h000
`define FND_ACC_RST       20'h00000
`define FND_LOCK_WIN      10000
`define FND_LOCK_TOL      16'h0002
`define FND_EXT_1M_RATIO  10
`define FND_PRE_DIV2_END  2'h1
`define FND_PRE_DIV3_END  2'h2
`endif

// ===== src/fnd_top.sv
// Fractional-N divider control top level.
//
// Function
// - Counter preset is nine's complement of integer.
// - Divide by 2N, 2N plus one when signalled.
// - Cascaded counters divide by programmed integer.
// - Prescaler divides two, three once per swallow.
// - Accumulator adds fraction once per divider output.
// - Carry at one issues swallow, remainder kept.
// - Divisor integer to counters, fraction to accumulator.
// - Swallow rate equals fraction times reference.
// - Integer divisor limited to tuning range.
// - Compensation sequence runs every reference cycle.
// - Bias charge, then compensation current added.
// - Five accumulator bits set current, interval.
// - Hold, detector discharge, then sample-hold retains.
// - Loop reference divided from crystal ticks.
// - External 1 or 10 MHz compared.
// - Unlock raised when reference out of range.
`timescale 1ns/1ps
`include "fnd_regs.svh"
module fnd_top
    import fnd_pkg::*;
#(
    parameter int LOCK_WIN = `FND_LOCK_WIN // Lock comparison window in 10 MHz ticks.
)
(
    input  wire logic        core_clk_in,     // Core clock, 10 MHz.
    input  wire logic        rstn_in,         // Asynchronous reset, active low.
    input  wire logic        vco_tick_in,     // One pulse per VCO cycle.
    input  wire logic        xtal_tick_in,    // One pulse per crystal cycle.
    input  wire logic        ext_tick_in,     // One pulse per external reference cycle.
    input  wire logic        ext_sel_10m_in,  // External reference is 10 MHz, else 1 MHz.
    input  wire logic        ext_en_in,       // Discipline to an external reference.
    input  wire logic        load_in,         // Divisor reload pulse.
    input  wire logic [11:0] int_bcd_in,      // Integer part, three BCD digits.
    input  wire fnd_frac_t   frac_bcd_in,     // Fractional part, five BCD digits.
    input  wire logic        pd_resp_in,      // Phase detector has responded.
    input  wire logic        pd_active_in,    // Phase detector current flows.
    output logic             div_out,         // Divided counter output pulse.
    output logic             ref_out,         // Loop reference pulse.
    output logic             swallow_out,     // Pulse-swallow command.
    output logic             bias_en_out,     // Bias charging enable.
    output logic             comp_en_out,     // Compensation current enable.
    output logic [4:0]       comp_level_out,  // Compensation current magnitude.
    output logic             disch_en_out,    // Detector discharge enable.
    output logic             sample_out,      // Sample-hold retain command.
    output logic             overrun_out,     // Tick while busy.
    output logic             divisor_err_out, // Last load was rejected.
    output logic             unlock_out       // External reference not captured.
);
    fnd_link_if link (); // Carrier between the three blocks.

    // Divisor held after an accepted load.
    logic [11:0] comp_q;       // Nine's complement of the integer part.
    fnd_frac_t   frac_q;       // Fractional part.
    logic        err_q;        // Rejected-load flag.
    logic        load_q;       // Accepted reload pulse toward the accumulator.

    // Validity of the requested divisor.
    wire logic int_digits_ok_w;
    wire logic frac_digits_ok_w;
    wire logic in_range_w;
    wire logic load_ok_w;
    wire logic [11:0] comp_w;

    // Each BCD nibble must be a decimal digit.
    function automatic logic digits_ok(input logic [19:0] v, input int n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < n; i++)
            ok = ok & (v[4*i +: 4] <= 4'h9);
        return ok;
    endfunction : digits_ok

    // Increment a three-digit BCD value.
    function automatic logic [11:0] bcd_inc(input logic [11:0] v);
        logic [11:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            if (c)
            begin
                if (r[4*i +: 4] == 4'h9)
                    r[4*i +: 4] = 4'h0;
                else
                begin
                    r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction : bcd_inc

    assign int_digits_ok_w  = digits_ok({8'h00, int_bcd_in}, 3);
    assign frac_digits_ok_w = digits_ok(frac_bcd_in, 5);
    // Only the oscillator tuning range is accepted.
    assign in_range_w = (int_bcd_in >= `FND_INT_MIN) & (int_bcd_in <= `FND_INT_MAX);
    assign load_ok_w  = int_digits_ok_w & frac_digits_ok_w & in_range_w;
    // Per-digit nine's complement: 9 - d.
    assign comp_w = {4'h9 - int_bcd_in[11:8], 4'h9 - int_bcd_in[7:4], 4'h9 - int_bcd_in[3:0]};

    // Latch the divisor; a rejected load keeps the old one.
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            comp_q <= `FND_PROG_RST;
            frac_q <= `FND_ACC_RST;
            err_q  <= 1'b0;
            load_q <= 1'b0;
        end
        else
        begin
            load_q <= load_in & load_ok_w;
            if (load_in)
                err_q <= ~load_ok_w;
            if (load_in & load_ok_w)
            begin
                comp_q <= comp_w;
                frac_q <= frac_bcd_in;
            end
        end
    end

    // Prescaler: two VCO pulses per cycle, three with a swallow pending.
    logic [1:0] pre_cnt_q;   // VCO pulses within the current prescaler cycle.
    logic       pend_q;      // Swallow waiting for or in its divide-by-three cycle.
    wire  logic [1:0] pre_end_w = pend_q ? `FND_PRE_DIV3_END : `FND_PRE_DIV2_END;
    wire  logic pre_tick_w = vco_tick_in & (pre_cnt_q == pre_end_w);

    // A swallow as a stretched cycle ends still counts: the set wins.
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pre_cnt_q <= 2'h0;
            pend_q    <= 1'b0;
        end
        else
        begin
            if (vco_tick_in)
                pre_cnt_q <= pre_tick_w ? 2'h0 : pre_cnt_q + 2'h1;
            pend_q <= link.swallow | (pend_q & ~pre_tick_w);
        end
    end

    // Decimal counter: complement up to 998,
    // so it spans exactly N prescaler cycles.
    logic [11:0] prog_q;     // Counter state.
    logic        div_q;      // Divider output pulse.
    wire  logic  prog_end_w = (prog_q == `FND_PROG_TERM);

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            prog_q <= `FND_PROG_RST;
            div_q  <= 1'b0;
        end
        else if (load_q)
        begin
            prog_q <= comp_q;
            div_q  <= 1'b0;
        end
        else
        begin
            div_q <= pre_tick_w & prog_end_w;
            if (pre_tick_w)
                prog_q <= prog_end_w ? comp_q : bcd_inc(prog_q);
        end
    end

    // Loop reference: the crystal tick stream divided down to 100 kHz.
    logic [`FND_REF_DIV_W-1:0] ref_cnt_q; // Crystal ticks in the current reference cycle.
    logic                      ref_q;     // Reference pulse.
    wire  logic ref_end_w = (ref_cnt_q == `FND_REF_DIV - 16'h0001);

    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ref_cnt_q <= 16'h0000;
            ref_q     <= 1'b0;
        end
        else
        begin
            ref_q <= xtal_tick_in & ref_end_w;
            if (xtal_tick_in)
                ref_cnt_q <= ref_end_w ? 16'h0000 : ref_cnt_q + 16'h0001;
        end
    end

    // Hand the link its drivers.
    assign link.div_tick = div_q;
    assign link.ref_tick = ref_q;
    assign link.load     = load_q;
    assign link.frac     = frac_q;

    // Accumulator: fraction summed per divider output, carry feeds the prescaler.
    fnd_bcd_acc u_acc (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .link        (link)
    );

    // Sequencer outputs before the final output flops.
    logic       seq_bias_w;
    logic       seq_comp_w;
    logic [4:0] seq_level_w;
    logic       seq_disch_w;
    logic       seq_sample_w;
    logic       seq_over_w;

    fnd_comp_seq u_seq (
        .core_clk_in  (core_clk_in),
        .rstn_in      (rstn_in),
        .link         (link),
        .pd_resp_in   (pd_resp_in),
        .pd_active_in (pd_active_in),
        .bias_en_out  (seq_bias_w),
        .comp_en_out  (seq_comp_w),
        .level_out    (seq_level_w),
        .disch_en_out (seq_disch_w),
        .sample_out   (seq_sample_w),
        .overrun_out  (seq_over_w)
    );

    // Lock detector: external ticks counted in a window of 10 MHz ticks
    // and compared with the selected reference's count.
    logic [2:0]  ten_cnt_q;   // Crystal ticks toward one 10 MHz tick.
    logic [15:0] win_cnt_q;   // 10 MHz ticks in the window.
    logic [15:0] ext_cnt_q;   // External ticks in the window.
    logic        unlock_q;    // Unlock indication.
    wire  logic ten_tick_w = xtal_tick_in & (ten_cnt_q == `FND_TEN_M_DIV - 3'd1);
    wire  logic win_end_w  = ten_tick_w & (win_cnt_q == 16'(LOCK_WIN - 1));
    wire  logic [15:0] expect_w = ext_sel_10m_in ? 16'(LOCK_WIN) : 16'(LOCK_WIN / `FND_EXT_1M_RATIO);
    wire  logic [15:0] diff_w = (ext_cnt_q > expect_w) ? ext_cnt_q - expect_w : expect_w - ext_cnt_q;
    wire  logic out_of_range_w = (diff_w > `FND_LOCK_TOL);

    // Refreshed once per window, so it lags a lost reference by one window.
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ten_cnt_q <= 3'd0;
            win_cnt_q <= 16'h0000;
            ext_cnt_q <= 16'h0000;
            unlock_q  <= 1'b0;
        end
        else
        begin
            if (xtal_tick_in)
                ten_cnt_q <= ten_tick_w ? 3'd0 : ten_cnt_q + 3'd1;
            if (ten_tick_w)
                win_cnt_q <= win_end_w ? 16'h0000 : win_cnt_q + 16'h0001;
            if (win_end_w)
            begin
                ext_cnt_q <= 16'(ext_tick_in);
                unlock_q  <= ext_en_in & out_of_range_w;
            end
            else if (ext_tick_in)
                ext_cnt_q <= ext_cnt_q + 16'h0001;
            if (!ext_en_in)
                unlock_q <= 1'b0;
        end
    end

    // Output flops: every port comes straight from a register.
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            div_out         <= 1'b0;
            ref_out         <= 1'b0;
            swallow_out     <= 1'b0;
            bias_en_out     <= 1'b0;
            comp_en_out     <= 1'b0;
            comp_level_out  <= 5'h00;
            disch_en_out    <= 1'b0;
            sample_out      <= 1'b0;
            overrun_out     <= 1'b0;
            divisor_err_out <= 1'b0;
            unlock_out      <= 1'b0;
        end
        else
        begin
            div_out         <= div_q;
            ref_out         <= ref_q;
            swallow_out     <= link.swallow;
            bias_en_out     <= seq_bias_w;
            comp_en_out     <= seq_comp_w;
            comp_level_out  <= seq_level_w;
            disch_en_out    <= seq_disch_w;
            sample_out      <= seq_sample_w;
            overrun_out     <= seq_over_w;
            divisor_err_out <= err_q;
            unlock_out      <= unlock_q;
        end
    end
endmodule : fnd_top
